// >>> i2c_slave_match_defines.svh
// Purpose: offsets, field positions, reset values for the slave match block
// Assumes: byte-addressed register port with registers 4 apart, 16-bit registers in the low bits of 32
// Notes:   included by bare name
`ifndef I2C_SLAVE_MATCH_DEFINES_SVH
`define I2C_SLAVE_MATCH_DEFINES_SVH

`define OFS_SLAVE_TX_DATA      32'h40003434
`define OFS_HW_GC_MATCH        32'h40003438
`define OFS_ADDR_MATCH_0       32'h4000343c
`define OFS_ADDR_MATCH_1       32'h40003440
`define OFS_ADDR_MATCH_2       32'h40003444
`define OFS_ADDR_MATCH_3       32'h40003448
`define OFS_SLAVE_CONTROL      32'h40003400
`define OFS_MATCH_STATUS       32'h40003404

`define CTRL_HW_GC_EN_BIT      3
`define CTRL_TEN_BIT_EN_BIT    1
`define CTRL_WIDTH             16

`define REG_RESET_VALUE        16'h0000
`define DATA_MSB               7
`define ID_COUNT               4
`define TEN_BIT_PREFIX         5'h1e

`endif

// >>> i2c_slave_match_pkg.sv
// Purpose: types for the slave match block
// Assumes: nothing
// Notes:   used as i2c_slave_match_pkg::name
package i2c_slave_match_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b11,
    ST_DONE   = 2'b10
  } match_state_t;
endpackage : i2c_slave_match_pkg

// >>> addr_compare.sv
// Purpose: compare one received address byte against four id registers
// Assumes: ids hold address in [7:1]; bit 0 is ignored except in the 10-bit second byte
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_match_defines.svh"
module addr_compare #(
  parameter int ID_COUNT = 4
) (
  // inputs
  input  wire logic [ID_COUNT*8-1:0] ids_i,
  input  wire logic [7:0]            rx_byte_i,
  input  wire logic                  ten_bit_i,
  input  wire logic                  second_i,
  // outputs
  output logic      [ID_COUNT-1:0]   hit_o
);
  genvar g;
  generate
    for (g = 0; g < ID_COUNT; g++) begin : g_cmp
      wire logic [7:0] id = ids_i[g*8 +: 8];
      // 10-bit: first byte carries prefix + top bits, second byte full low byte
      assign hit_o[g] = !ten_bit_i ? (rx_byte_i[7:1] == id[7:1]) :
                        (second_i ? (rx_byte_i == id) :
                         (rx_byte_i[7:3] == `TEN_BIT_PREFIX && rx_byte_i[2:1] == id[2:1]));
    end
  endgenerate
endmodule : addr_compare
`default_nettype wire

// >>> i2c_slave_addr_match_tx.sv
// Purpose: slave transmit byte, hw general call match and four address ids
// Assumes: received bytes arrive from shift logic on clk_i as one-cycle strobes
// Notes:   10-bit mode uses id[2:1] in the first byte and the full id in the second
//
// Function
// - the transmit data register holds a read/write byte in [7:0] and reads zero above.
// - with hw general call enable set, the second call byte is matched against the match value.
// - the match value recognises a master's own address for masters that cannot be programmed.
// - id 0 holds a 7-bit address in [7:1] and bit 0 is ignored in comparison.
// - three more ids behave like id 0 and read zero in [15:8].
// - with 10-bit addressing on, ids are read as parts of a 10-bit address.
// - the match value and all four ids reset to zero.
// - the second byte of a hw general call is pushed into the receive fifo.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_match_defines.svh"
module i2c_slave_addr_match_tx #(
  parameter int ID_COUNT = `ID_COUNT
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // byte stream from the shift logic
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        tx_take_i,
  // results
  output logic             addr_ack_o,
  output logic             addressed_o,
  output logic [1:0]       match_id_o,
  output logic             hw_gc_hit_o,
  output logic             rx_push_o,
  output logic [7:0]       rx_push_data_o,
  output logic [7:0]       tx_byte_o,
  output logic             tx_load_o
);
  logic [7:0]            slave_tx_byte;
  logic [7:0]            gc_match_value;
  logic [ID_COUNT*8-1:0] ids;
  logic [`CTRL_WIDTH-1:0] slave_control;
  i2c_slave_match_pkg::match_state_t state;
  i2c_slave_match_pkg::match_state_t next_state;
  logic                  gc_pending;

  // register decode
  wire logic sel_tx   = addr_i == `OFS_SLAVE_TX_DATA;
  wire logic sel_gc   = addr_i == `OFS_HW_GC_MATCH;
  wire logic sel_ctl  = addr_i == `OFS_SLAVE_CONTROL;
  wire logic sel_sta  = addr_i == `OFS_MATCH_STATUS;
  wire logic [ID_COUNT-1:0] sel_id;
  genvar g;
  generate
    for (g = 0; g < ID_COUNT; g++) begin : g_sel
      assign sel_id[g] = addr_i == (`OFS_ADDR_MATCH_0 + 32'(g * 4));
    end
  endgenerate

  wire logic hw_gc_en   = slave_control[`CTRL_HW_GC_EN_BIT];
  wire logic ten_bit_en = slave_control[`CTRL_TEN_BIT_EN_BIT];

  // address comparison
  wire logic [ID_COUNT-1:0] id_hit;
  addr_compare #(.ID_COUNT(ID_COUNT)) u_cmp (
    .ids_i     (ids),
    .rx_byte_i (rx_byte_i),
    .ten_bit_i (ten_bit_en),
    .second_i  (state == i2c_slave_match_pkg::ST_FIRST),
    .hit_o     (id_hit)
  );

  function automatic logic [1:0] first_hit(input logic [3:0] h);
    first_hit = h[0] ? 2'h0 : h[1] ? 2'h1 : h[2] ? 2'h2 : 2'h3;
  endfunction

  wire logic any_hit   = |id_hit;
  wire logic gc_header = rx_byte_i == 8'h00;
  wire logic in_idle   = state == i2c_slave_match_pkg::ST_IDLE;
  wire logic in_first  = state == i2c_slave_match_pkg::ST_FIRST;
  wire logic in_second = state == i2c_slave_match_pkg::ST_SECOND;
  // single-byte address ends in done; 10-bit needs a second byte
  wire logic take_first  = rx_valid_i && in_idle && any_hit;
  wire logic take_second = rx_valid_i && in_first && any_hit;
  wire logic ack_now     = (take_first && !ten_bit_en) || take_second;
  // hw general call: byte after 0x00 compared with the match value
  wire logic gc_hit_now  = rx_valid_i && gc_pending && hw_gc_en &&
                           rx_byte_i == gc_match_value;

  always_comb begin
    next_state = state;
    case (state)
      i2c_slave_match_pkg::ST_IDLE: begin
        if (take_first)
          next_state = ten_bit_en ? i2c_slave_match_pkg::ST_FIRST
                                  : i2c_slave_match_pkg::ST_DONE;
        else if (rx_valid_i && gc_header && hw_gc_en)
          next_state = i2c_slave_match_pkg::ST_SECOND;
      end
      i2c_slave_match_pkg::ST_FIRST: begin
        if (rx_valid_i)
          next_state = any_hit ? i2c_slave_match_pkg::ST_DONE
                               : i2c_slave_match_pkg::ST_IDLE;
      end
      i2c_slave_match_pkg::ST_SECOND: begin
        if (rx_valid_i)
          next_state = i2c_slave_match_pkg::ST_IDLE;
      end
      i2c_slave_match_pkg::ST_DONE: next_state = i2c_slave_match_pkg::ST_DONE;
      default: next_state = i2c_slave_match_pkg::ST_IDLE;
    endcase
    if (start_i || stop_i)
      next_state = i2c_slave_match_pkg::ST_IDLE;
  end

  wire logic [15:0] id_rd = sel_id[0] ? {8'h00, ids[7:0]} :
                            sel_id[1] ? {8'h00, ids[15:8]} :
                            sel_id[2] ? {8'h00, ids[23:16]} :
                            sel_id[3] ? {8'h00, ids[31:24]} : 16'h0000;
  wire logic [15:0] sta_rd = {11'h000, hw_gc_hit_o, match_id_o, addressed_o, in_first};
  // unmapped addresses read zero
  wire logic [15:0] rd_mux = sel_tx  ? {8'h00, slave_tx_byte} :
                             sel_gc  ? {8'h00, gc_match_value} :
                             sel_ctl ? slave_control :
                             sel_sta ? sta_rd : id_rd;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      slave_tx_byte  <= 8'h00;
      gc_match_value <= 8'h00;
      ids            <= '0;
      slave_control  <= `REG_RESET_VALUE;
    end else if (wr_i) begin
      if (sel_tx)  slave_tx_byte  <= wdata_i[`DATA_MSB:0];
      if (sel_gc)  gc_match_value <= wdata_i[`DATA_MSB:0];
      if (sel_ctl) slave_control  <= wdata_i[`CTRL_WIDTH-1:0];
      for (int i = 0; i < ID_COUNT; i++)
        if (sel_id[i]) ids[i*8 +: 8] <= wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state          <= i2c_slave_match_pkg::ST_IDLE;
      gc_pending     <= 1'b0;
      rdata_o        <= 32'h0000_0000;
      addr_ack_o     <= 1'b0;
      addressed_o    <= 1'b0;
      match_id_o     <= 2'h0;
      hw_gc_hit_o    <= 1'b0;
      rx_push_o      <= 1'b0;
      rx_push_data_o <= 8'h00;
      tx_byte_o      <= 8'h00;
      tx_load_o      <= 1'b0;
    end else begin
      state       <= next_state;
      gc_pending  <= (start_i || stop_i) ? 1'b0 : (next_state == i2c_slave_match_pkg::ST_SECOND);
      rdata_o     <= rd_i ? {16'h0000, rd_mux} : 32'h0000_0000;
      addr_ack_o  <= ack_now;
      if (start_i || stop_i)
        addressed_o <= 1'b0;
      else if (ack_now)
        addressed_o <= 1'b1;
      if (ack_now)
        match_id_o <= first_hit(id_hit);
      // a call byte landing with a start still counts: the set wins
      if (gc_hit_now)
        hw_gc_hit_o <= 1'b1;
      else if (start_i)
        hw_gc_hit_o <= 1'b0;
      // second call byte goes to the receive fifo whether or not it matched
      rx_push_o      <= rx_valid_i && in_second;
      rx_push_data_o <= rx_byte_i;
      tx_load_o      <= tx_take_i;
      if (tx_take_i)
        tx_byte_o <= slave_tx_byte;
    end
  end

  property p_reset_zero;
    @(posedge clk_i) !reset_n_i |=> (gc_match_value == 8'h00 && ids == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("match regs not zero after reset");

  property p_tx_write;
    @(posedge clk_i) disable iff (!reset_n_i)
      (wr_i && sel_tx) |=> slave_tx_byte == $past(wdata_i[7:0]);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx byte not stored");

  property p_read_upper_zero;
    @(posedge clk_i) disable iff (!reset_n_i) rd_i && (sel_tx || sel_gc || |sel_id) |=> rdata_o[31:8] == 24'h0;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("reserved bits not zero");

  property p_ack_on_hit;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rx_valid_i && in_idle && !ten_bit_en && any_hit && !start_i && !stop_i) |=> addr_ack_o && addressed_o;
  endproperty
  a_ack_on_hit: assert property (p_ack_on_hit) else $error("address hit not acknowledged");

  property p_bit0_ignored;
    @(posedge clk_i) disable iff (!reset_n_i)
      !ten_bit_en |-> id_hit[0] == (rx_byte_i[7:1] == ids[7:1]);
  endproperty
  a_bit0_ignored: assert property (p_bit0_ignored) else $error("id0 compare wrong");

  property p_ten_bit_two_bytes;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ten_bit_en && take_first) |=> !addr_ack_o;
  endproperty
  a_ten_bit_two_bytes: assert property (p_ten_bit_two_bytes) else $error("10-bit acked on first byte");

  property p_gc_match;
    @(posedge clk_i) disable iff (!reset_n_i) gc_hit_now && !start_i |=> hw_gc_hit_o;
  endproperty
  a_gc_match: assert property (p_gc_match) else $error("hw general call not matched");

  property p_gc_needs_value;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(hw_gc_hit_o) |-> $past(rx_byte_i) == $past(gc_match_value);
  endproperty
  a_gc_needs_value: assert property (p_gc_needs_value) else $error("call matched wrong value");

  sequence s_gc_header;
    rx_valid_i && in_idle && gc_header && hw_gc_en && !start_i && !stop_i;
  endsequence
  sequence s_gc_second;
    rx_valid_i && !start_i && !stop_i;
  endsequence
  property p_gc_push;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_gc_header ##1 s_gc_second |=> rx_push_o && rx_push_data_o == $past(rx_byte_i);
  endproperty
  a_gc_push: assert property (p_gc_push) else $error("call byte not pushed");

  // reads return the register in [7:0] and zero above, one cycle after the strobe
  property p_tx_read;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && sel_tx) |=> rdata_o == {24'h000000, $past(slave_tx_byte)};
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("tx byte read wrong");

  property p_tx_load;
    @(posedge clk_i) disable iff (!reset_n_i)
      tx_take_i |=> tx_load_o && tx_byte_o == $past(slave_tx_byte);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx byte not loaded");

  property p_tx_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      !tx_take_i |=> !tx_load_o && $stable(tx_byte_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved without take");

  property p_gc_read;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && sel_gc) |=> rdata_o == {24'h000000, $past(gc_match_value)};
  endproperty
  a_gc_read: assert property (p_gc_read) else $error("match value read wrong");

  property p_gc_needs_enable;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(hw_gc_hit_o) |-> $past(hw_gc_en);
  endproperty
  a_gc_needs_enable: assert property (p_gc_needs_enable) else $error("call matched while disabled");

  property p_gc_clear;
    @(posedge clk_i) disable iff (!reset_n_i)
      (start_i && !gc_hit_now) |=> !hw_gc_hit_o;
  endproperty
  a_gc_clear: assert property (p_gc_clear) else $error("call hit survived start");

  property p_id0_read;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && sel_id[0]) |=> rdata_o == {24'h000000, $past(ids[7:0])};
  endproperty
  a_id0_read: assert property (p_id0_read) else $error("id 0 read wrong");

  property p_id3_read;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && sel_id[3]) |=> rdata_o == {24'h000000, $past(ids[31:24])};
  endproperty
  a_id3_read: assert property (p_id3_read) else $error("id 3 read wrong");

  // 10-bit: prefix and an id match in the first byte wait for the low byte
  sequence s_ten_first;
    rx_valid_i && in_idle && ten_bit_en && !start_i && !stop_i &&
    rx_byte_i[7:3] == `TEN_BIT_PREFIX && any_hit;
  endsequence
  property p_ten_bit_first;
    @(posedge clk_i) disable iff (!reset_n_i) s_ten_first |=> in_first;
  endproperty
  a_ten_bit_first: assert property (p_ten_bit_first) else $error("10-bit first byte not taken");

  sequence s_ten_second;
    rx_valid_i && in_first && any_hit && !start_i && !stop_i;
  endsequence
  property p_ten_bit_second;
    @(posedge clk_i) disable iff (!reset_n_i) s_ten_second |=> addr_ack_o && addressed_o;
  endproperty
  a_ten_bit_second: assert property (p_ten_bit_second) else $error("10-bit low byte not acked");

  property p_ten_bit_low_byte;
    @(posedge clk_i) disable iff (!reset_n_i)
      (in_first && ten_bit_en) |-> id_hit[1] == (rx_byte_i == ids[15:8]);
  endproperty
  a_ten_bit_low_byte: assert property (p_ten_bit_low_byte) else $error("10-bit low byte compare wrong");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (!reset_n_i) addr_ack_o |=> !addr_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_addr_clear;
    @(posedge clk_i) disable iff (!reset_n_i) (start_i || stop_i) |=> !addressed_o;
  endproperty
  a_addr_clear: assert property (p_addr_clear) else $error("addressed kept past start or stop");

  property p_addr_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      (addressed_o && !start_i && !stop_i) |=> addressed_o;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addressed dropped mid frame");

  property p_id_only_at_ack;
    @(posedge clk_i) disable iff (!reset_n_i) $changed(match_id_o) |-> addr_ack_o;
  endproperty
  a_id_only_at_ack: assert property (p_id_only_at_ack) else $error("match id moved without ack");

  property p_push_source;
    @(posedge clk_i) disable iff (!reset_n_i) rx_push_o |-> $past(rx_valid_i) && $past(in_second);
  endproperty
  a_push_source: assert property (p_push_source) else $error("push outside a hw call");

  property p_push_pulse;
    @(posedge clk_i) disable iff (!reset_n_i) rx_push_o |=> !rx_push_o;
  endproperty
  a_push_pulse: assert property (p_push_pulse) else $error("push longer than one cycle");

  // strobes must be quiet after reset so the shift logic never sees a stale one
  property p_reset_quiet;
    @(posedge clk_i) !reset_n_i |=> !addr_ack_o && !addressed_o && !hw_gc_hit_o && !rx_push_o && !tx_load_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");

  property p_reset_tx_zero;
    @(posedge clk_i) !reset_n_i |=> slave_tx_byte == 8'h00 && rdata_o == 32'h0000_0000;
  endproperty
  a_reset_tx_zero: assert property (p_reset_tx_zero) else $error("tx byte or read data not cleared");
endmodule : i2c_slave_addr_match_tx
`default_nettype wire

// >>> i2c_master_model.sv
// Purpose: far-side bus master, sends a start and one or two address bytes
// Assumes: bytes arrive already deserialised, one-cycle valid strobes
// Notes:   gap_i stretches the frame so slow masters are covered too
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // control
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       go_i,
  input  wire logic       two_i,
  input  wire logic [1:0] gap_i,
  input  wire logic [7:0] b0_i,
  input  wire logic [7:0] b1_i,
  // toward the slave
  output logic            start_o,
  output logic            valid_o,
  output logic            busy_o,
  output logic      [7:0] byte_o
);
  logic       step;
  logic [1:0] wait_q;
  // outside a valid strobe and the start cycle the byte lines toggle so stale data never looks valid
  always_ff @(posedge clk_i) begin
    start_o <= 1'b0;
    valid_o <= 1'b0;
    if (!reset_n_i) begin
      busy_o <= 1'b0;
      step   <= 1'b0;
      wait_q <= 2'h0;
      byte_o <= 8'h00;
    end else if (go_i && !busy_o) begin
      busy_o  <= 1'b1;
      start_o <= 1'b1;
      step    <= 1'b0;
      wait_q  <= gap_i;
    end else if (busy_o && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
      byte_o <= ~byte_o;
    end else if (busy_o) begin
      valid_o <= 1'b1;
      byte_o  <= step ? b1_i : b0_i;
      busy_o  <= two_i && !step;
      step    <= 1'b1;
      wait_q  <= gap_i;
    end else begin
      byte_o <= ~byte_o;
    end
  end
endmodule : i2c_master_model
`default_nettype wire

// >>> tb.sv
// Purpose: self-checking bench for the slave match and transmit byte block
// Assumes: register port answers reads one cycle later
// Notes:   random values from an xorshift seeded with 38
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_match_defines.svh"
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb;
  logic clk_i, reset_n_i, wr_i, rd_i, tx_take_i, stop_i, go, two;
  logic [31:0] addr_i, wdata_i, rdata_o, seed, rv, d;
  logic start_i, rx_valid_i, busy, addr_ack_o, addressed_o, hw_gc_hit_o, rx_push_o, tx_load_o;
  logic [7:0] rx_byte_i, rx_push_data_o, tx_byte_o, b0, b1, push_q;
  logic [7:0] ids [4];
  logic [1:0] match_id_o, gap;
  int n_mismatch, checks_done, n_ack, n_push, n_load;
  i2c_slave_addr_match_tx dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .start_i(start_i), .stop_i(stop_i), .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i), .tx_take_i(tx_take_i), .addr_ack_o(addr_ack_o), .addressed_o(addressed_o),
    .match_id_o(match_id_o), .hw_gc_hit_o(hw_gc_hit_o), .rx_push_o(rx_push_o),
    .rx_push_data_o(rx_push_data_o), .tx_byte_o(tx_byte_o), .tx_load_o(tx_load_o));
  i2c_master_model mst (.clk_i(clk_i), .reset_n_i(reset_n_i), .go_i(go), .two_i(two), .gap_i(gap),
    .b0_i(b0), .b1_i(b1), .start_o(start_i), .valid_o(rx_valid_i), .busy_o(busy), .byte_o(rx_byte_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  always @(posedge clk_i) begin
    if (addr_ack_o === 1'b1) n_ack++;
    if (tx_load_o === 1'b1) n_load++;
    if (rx_push_o === 1'b1) begin
      n_push++;
      push_q = rx_push_data_o;
    end
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_i) begin addr_i <= a; wdata_i <= v; wr_i <= 1'b1; end
    @(posedge clk_i) wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge clk_i) begin addr_i <= a; rd_i <= 1'b1; end
    @(posedge clk_i) rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic send(input logic [7:0] x, input logic [7:0] y, input logic t);
    n_ack = 0;
    n_push = 0;
    @(posedge clk_i) begin go <= 1'b1; b0 <= x; b1 <= y; two <= t; gap <= 2'(rnd()); end
    @(posedge clk_i) go <= 1'b0;
    #1;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk_i);
    if (busy !== 1'b0) final_report();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : send
  task automatic pulse_stop();
    @(posedge clk_i) stop_i <= 1'b1;
    @(posedge clk_i) stop_i <= 1'b0;
    #1;
  endtask : pulse_stop
  task automatic final_report();
    if (busy !== 1'b0) n_mismatch++;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    seed = 32'd38;
    {reset_n_i, wr_i, rd_i, tx_take_i, stop_i, go, two, gap} = '0;
    {addr_i, wdata_i, b0, b1} = '0;
    repeat (2) @(posedge clk_i);
    @(posedge clk_i) reset_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(`OFS_SLAVE_TX_DATA + 32'(4 * i), rv);
      `CHK(rv, 32'h0000_0000, "reset value")
    end
    rd(32'h4000_3500, rv);
    `CHK(rv, 32'h0000_0000, "unmapped read")
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      wr(`OFS_SLAVE_TX_DATA + 32'(4 * i), d);
      rd(`OFS_SLAVE_TX_DATA + 32'(4 * i), rv);
      `CHK(rv, {24'h0, d[7:0]}, "readback")
    end
    $display("registers done");
    // distinct [2:1] keeps the lowest-index choice unambiguous
    for (int j = 0; j < 4; j++) begin
      d = rnd();
      ids[j] = {1'b1, d[6:3], 2'(j), d[0]};
      wr(`OFS_ADDR_MATCH_0 + 32'(4 * j), {24'h0, ids[j]});
    end
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      send({ids[k][7:1], d[0]}, 8'h00, 1'b0);
      `CHK(n_ack, 1, "no ack")
      `CHK(match_id_o, 2'(k), "match id")
      `CHK(addressed_o, 1'b1, "not addressed")
      rd(`OFS_MATCH_STATUS, rv);
      `CHK(rv, {27'h0, 1'b0, 2'(k), 1'b1, 1'b0}, "status")
      pulse_stop();
      `CHK(addressed_o, 1'b0, "stop ignored")
    end
    send(8'h02, 8'h00, 1'b0);
    `CHK(n_ack, 0, "false ack")
    $display("seven bit done");
    wr(`OFS_SLAVE_CONTROL, 32'h8);
    wr(`OFS_HW_GC_MATCH, 32'h137);
    send(8'h00, 8'h37, 1'b1);
    `CHK(n_push, 1, "no push")
    `CHK(push_q, 8'h37, "push data")
    `CHK(hw_gc_hit_o, 1'b1, "gc miss")
    send(8'h00, 8'h38, 1'b1);
    `CHK(hw_gc_hit_o, 1'b0, "gc wrong master")
    wr(`OFS_SLAVE_CONTROL, 32'h0);
    send(8'h00, 8'h37, 1'b1);
    `CHK(hw_gc_hit_o, 1'b0, "gc while off")
    $display("general call done");
    wr(`OFS_SLAVE_CONTROL, 32'h2);
    send({5'h1e, ids[1][2:1], 1'b0}, ids[1], 1'b1);
    `CHK(n_ack, 1, "ten bit ack")
    `CHK(match_id_o, 2'h1, "ten bit id")
    pulse_stop();
    $display("ten bit done");
    d = rnd();
    wr(`OFS_SLAVE_TX_DATA, d);
    n_load = 0;
    @(posedge clk_i) tx_take_i <= 1'b1;
    @(posedge clk_i) tx_take_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(n_load, 1, "tx load")
    `CHK(tx_byte_o, d[7:0], "tx byte")
    $display("transmit done");
    @(posedge clk_i) reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(`OFS_SLAVE_TX_DATA + 32'(4 * i), rv);
      `CHK(rv, 32'h0000_0000, "reset clears")
    end
    $display("reset done");
    final_report();
  end
endmodule : tb
`default_nettype wire
